// ---- rtl/oep_pkg.sv ----
package oep_pkg;
	localparam int NUM_PAIRS = 4;
	localparam int CLK_HZ    = 20000000;
	localparam int CLK_NS    = 50;

	// Start-up and wake latencies, kept as printed.
	localparam int FIRST_CLK_MAX_US = 1000;
	localparam int PD_EXIT_MAX_US   = 300;
	// Longest times round down to whole cycles.
	localparam int FIRST_CLK_CYC = (FIRST_CLK_MAX_US * 1000) / CLK_NS;
	localparam int PD_EXIT_CYC   = (PD_EXIT_MAX_US * 1000) / CLK_NS;

	// Enable-pin latency in output clock cycles.
	localparam int OE_LAT_MIN = 1;
	localparam int OE_LAT_MAX = 3;
	localparam int OE_SYNC_STAGES = 2;

	// Management bus slave addresses chosen by the strap.
	localparam logic [6:0] ADDR_STRAP_LOW  = 7'h68;
	localparam logic [6:0] ADDR_STRAP_HIGH = 7'h6A;

	// Spread encodings, and the three-level select input codes.
	typedef enum logic [1:0]
	{
		SPREAD_OFF  = 2'h0,
		SPREAD_Q25  = 2'h1,
		SPREAD_HALF = 2'h2
	} oep_spread_t;

	localparam logic [1:0] TRI_LOW  = 2'h0;
	localparam logic [1:0] TRI_MID  = 2'h1;
	localparam logic [1:0] TRI_HIGH = 2'h2;

	typedef enum logic [3:0]
	{
		ST_COLD  = 4'h1,
		ST_START = 4'h2,
		ST_RUN   = 4'h4,
		ST_DOWN  = 4'h8
	} oep_state_t;

	// Straps captured on the first power-good.
	typedef struct packed
	{
		logic        valid;
		logic [6:0]  slaveAddr;
		oep_spread_t spread;
	} oep_straps_t;

	// Reference pin: out value and output enable.
	typedef struct packed
	{
		logic value;
		logic oe;
	} oep_ref_pin_t;
endpackage

// ---- rtl/oep_pair_gate.sv ----
`timescale 1ns/1ps
// Gates one differential pair on a whole output clock cycle; outputsAllow low stops it at the next mclk edge.
module oep_pair_gate #(
	parameter int SYNC_STAGES = oep_pkg::OE_SYNC_STAGES
)
(
	input  wire logic mclk,         // Block clock.
	input  wire logic reset,        // Asynchronous reset, active high.
	input  wire logic outClkTick,   // One pulse per output clock cycle.
	input  wire logic outPhase,     // Output clock phase, low at cycle start.
	input  wire logic enableN,      // Pair enable pin, active low.
	input  wire logic mgmtEnable,   // Management enable bit.
	input  wire logic outputsAllow, // Power-good and start-up done.
	output logic      trueOut,      // True output.
	output logic      compOut       // Complement output.
);
	// More stages than this would push the pin latency past its upper bound.
	if (SYNC_STAGES < 1 || SYNC_STAGES > oep_pkg::OE_LAT_MAX - 1)
	begin : gBadStages
		$error("oep_pair_gate: SYNC_STAGES out of range");
	end

	logic [SYNC_STAGES-1:0] syncQ, syncD;
	logic                   runQ, runD;
	logic                   trueQ, trueD;
	logic                   compQ, compD;
	logic                   wantRun;

	// Stages advance once per output cycle so latency counts in output clocks.
	assign wantRun = outputsAllow & ~enableN & mgmtEnable;

	always_comb
	begin
		syncD = syncQ;
		runD  = runQ;
		trueD = trueQ;
		compD = compQ;
		if (outClkTick)
		begin
			// Keeping the low bits drops the oldest stage, for any stage count.
			syncD = SYNC_STAGES'({syncQ, wantRun});
			runD = syncQ[SYNC_STAGES-1];
		end
		// Pin decision only at a cycle boundary, so the pin makes no runt pulse; outputsAllow low below cuts the pair at any mclk edge.
		trueD = runD & outPhase;
		compD = runD & ~outPhase;
		if (!outputsAllow)
		begin
			runD  = 1'b0;
			trueD = 1'b0;
			compD = 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			syncQ <= '0;
			runQ  <= 1'b0;
			trueQ <= 1'b0;
			compQ <= 1'b0;
		end
		else
		begin
			syncQ <= syncD;
			runQ  <= runD;
			trueQ <= trueD;
			compQ <= compD;
		end
	end

	assign trueOut = trueQ;
	assign compOut = compQ;
endmodule

// ---- rtl/oep_output_ctrl.sv ----
`timescale 1ns/1ps
// Overview of operation
// - Strap sampled once on first power-good; low gives 1101000, high 1101010.
// - Reference floats until first power-good, then driven low while power-good low.
// - Pair runs only with power-good high, pin low, enable bit one.
// - Pair enable pins active low; undriven pin pulled down enables pair.
// - Straps captured on first power-good only; never re-sampled afterwards.
// - Power-good low enters power-down; later high exits it; pin pulled up.
// - Spread select latched at power-up: high -0.5%, mid -0.25%, low off.
// - Pair starts and stops one to three output cycles after its pin.
// - First output clock within 1 ms of power-up or power-down exit.
// - Outputs enabled within 300 us of power-down release.
// - Shared pin is strap input before start-up, reference output after.
// - Four pairs, each with its own pin and management enable bit.
module oep_output_ctrl #(
	parameter int NUM_PAIRS   = oep_pkg::NUM_PAIRS,
	parameter int COLD_CYC    = oep_pkg::FIRST_CLK_CYC,
	parameter int WAKE_CYC    = oep_pkg::PD_EXIT_CYC,
	parameter int OUT_DIV     = 2
)
(
	input  wire logic                 mclk,                 // Block clock, 20 MHz.
	input  wire logic                 reset,                // Asynchronous reset, active high.
	input  wire logic                 powerGoodPowerdownN,  // Power-good, low is power-down.
	input  wire logic [NUM_PAIRS-1:0] pairEnableN,          // Pair enable pins, active low.
	input  wire logic [NUM_PAIRS-1:0] pairMgmtEnable,       // Management enable bits.
	input  wire logic                 addressSelectStrapIn, // Shared pin, input side.
	input  wire logic [1:0]           spreadSelectTri,      // Three-level spread select code.
	output logic [NUM_PAIRS-1:0]      pairTrueOut,          // Pair true outputs.
	output logic [NUM_PAIRS-1:0]      pairCompOut,          // Pair complement outputs.
	output logic                      referenceClockOut,    // Shared pin, output value.
	output logic                      referenceClockOe,     // Shared pin, output enable.
	output oep_pkg::oep_straps_t      straps,               // Captured strap values.
	output logic                      powerDown             // High while in power-down.
);
	if (NUM_PAIRS != oep_pkg::NUM_PAIRS)
	begin : gBadPairs
		$error("oep_output_ctrl: four pairs only");
	end
	if (COLD_CYC < 1 || WAKE_CYC < 1 || WAKE_CYC > COLD_CYC)
	begin : gBadCounts
		$error("oep_output_ctrl: bad start-up counts");
	end
	// The divider counter is eight bits wide.
	if (OUT_DIV < 2 || OUT_DIV > 255)
	begin : gBadDiv
		$error("oep_output_ctrl: OUT_DIV out of range");
	end

	localparam int CW = $clog2(COLD_CYC + 1);

	function automatic logic [CW-1:0] cycles(input int n);
		cycles = n[CW-1:0];
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Output clock divider: one tick per output cycle, phase for each half.

	logic [7:0] divQ, divD;
	logic       phaseQ, phaseD;
	logic       tickQ, tickD;

	always_comb
	begin
		divD   = divQ + 8'h01;
		phaseD = phaseQ;
		tickD  = 1'b0;
		if (divQ == 8'((OUT_DIV / 2) - 1))
			phaseD = 1'b1;
		if (divQ == 8'(OUT_DIV - 1))
		begin
			divD   = 8'h00;
			phaseD = 1'b0;
			tickD  = 1'b1;
		end
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			divQ   <= 8'h00;
			phaseQ <= 1'b0;
			tickQ  <= 1'b0;
		end
		else
		begin
			divQ   <= divD;
			phaseQ <= phaseD;
			tickQ  <= tickD;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Power sequencing and strap capture.

	oep_pkg::oep_state_t  stateQ, stateD;
	oep_pkg::oep_straps_t strapQ, strapD;
	logic [CW-1:0]        cntQ, cntD;
	logic                 allowQ, allowD;
	logic                 refOeQ, refOeD;
	logic                 refValQ, refValD;
	logic                 pdQ, pdD;

	always_comb
	begin
		stateD  = stateQ;
		strapD  = strapQ;
		cntD    = cntQ;
		allowD  = 1'b0;
		refOeD  = refOeQ;
		refValD = 1'b0;
		pdD     = ~powerGoodPowerdownN;
		case (stateQ)
			oep_pkg::ST_COLD:
			begin
				refOeD = 1'b0;
				if (powerGoodPowerdownN)
				begin
					// Straps taken once here and never again.
					strapD.valid     = 1'b1;
					strapD.slaveAddr = addressSelectStrapIn ? oep_pkg::ADDR_STRAP_HIGH
						: oep_pkg::ADDR_STRAP_LOW;
					case (spreadSelectTri)
						oep_pkg::TRI_HIGH: strapD.spread = oep_pkg::SPREAD_HALF;
						oep_pkg::TRI_MID:  strapD.spread = oep_pkg::SPREAD_Q25;
						default:           strapD.spread = oep_pkg::SPREAD_OFF;
					endcase
					cntD   = cycles(COLD_CYC - 1);
					stateD = oep_pkg::ST_START;
				end
			end
			oep_pkg::ST_START:
			begin
				refOeD = 1'b1;
				if (!powerGoodPowerdownN)
					stateD = oep_pkg::ST_DOWN;
				else if (cntQ == '0)
					stateD = oep_pkg::ST_RUN;
				else
					cntD = cntQ - cycles(1);
			end
			oep_pkg::ST_RUN:
			begin
				refOeD = 1'b1;
				allowD = powerGoodPowerdownN;
				refValD = powerGoodPowerdownN & phaseD;
				if (!powerGoodPowerdownN)
					stateD = oep_pkg::ST_DOWN;
			end
			oep_pkg::ST_DOWN:
			begin
				refOeD = 1'b1;
				if (powerGoodPowerdownN)
				begin
					// Wake from power-down uses the shorter bound of the two.
					cntD   = cycles(WAKE_CYC - 1);
					stateD = oep_pkg::ST_START;
				end
			end
			default:
			begin
				stateD = oep_pkg::ST_COLD;
				refOeD = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			stateQ  <= oep_pkg::ST_COLD;
			strapQ  <= '{valid: 1'b0, slaveAddr: 7'h00, spread: oep_pkg::SPREAD_OFF};
			cntQ    <= '0;
			allowQ  <= 1'b0;
			refOeQ  <= 1'b0;
			refValQ <= 1'b0;
			pdQ     <= 1'b0;
		end
		else
		begin
			stateQ  <= stateD;
			strapQ  <= strapD;
			cntQ    <= cntD;
			allowQ  <= allowD;
			refOeQ  <= refOeD;
			refValQ <= refValD;
			pdQ     <= pdD;
		end
	end

	assign referenceClockOut = refValQ;
	assign referenceClockOe  = refOeQ;
	assign straps            = strapQ;
	assign powerDown         = pdQ;

	////////////////////////////////////////////////////////////////////////
	// Four independently gated pairs.

	for (genvar p = 0; p < NUM_PAIRS; p++)
	begin : gPair
		oep_pair_gate uGate
		(
			.mclk         (mclk),
			.reset        (reset),
			.outClkTick   (tickQ),
			.outPhase     (phaseQ),
			.enableN      (pairEnableN[p]),
			.mgmtEnable   (pairMgmtEnable[p]),
			.outputsAllow (allowQ & powerGoodPowerdownN),
			.trueOut      (pairTrueOut[p]),
			.compOut      (pairCompOut[p])
		);
	end
endmodule

// ---- dv/oep_pwr_model.sv ----
`timescale 1ns/1ps
module oep_pwr_model (
	input  wire logic       pgDrv,    // Power-good level.
	input  wire logic       pgOe,     // Power-good driven.
	input  wire logic [3:0] enDrv,    // Pair pin levels.
	input  wire logic [3:0] enOe,     // Pair pins driven.
	input  wire logic       strapLvl, // Strap resistor level.
	input  wire logic       refOut,   // Shared pin value.
	input  wire logic       refOe,    // Shared pin enable.
	output logic            pg,       // Resolved power-good.
	output logic [3:0]      en,       // Resolved pair pins.
	output logic            strapPin  // Resolved shared pin.
);
	// A released controller must leave the clocks on, hence the pull-up.
	assign pg = pgOe ? pgDrv : 1'h1;
	assign en = enDrv & enOe;
	assign strapPin = refOe ? refOut : strapLvl;
endmodule

// ---- dv/oep_output_ctrl_chk.sv ----
`timescale 1ns/1ps
module oep_output_ctrl_chk #(
	parameter int NUM_PAIRS = 4
)
(
	input wire logic                 mclk,  // Clock.
	input wire logic                 reset, // Reset.
	input wire logic                 powerGoodPowerdownN, // Power-good.
	input wire logic [NUM_PAIRS-1:0] pairEnableN,         // Pair pins.
	input wire logic                 addressSelectStrapIn, // Strap.
	input wire logic [1:0]           spreadSelectTri,      // Spread.
	input wire logic [NUM_PAIRS-1:0] pairTrueOut, // True outputs.
	input wire logic [NUM_PAIRS-1:0] pairCompOut, // Comp outputs.
	input wire logic                 referenceClockOut, // Ref value.
	input wire logic                 referenceClockOe,  // Ref enable.
	input oep_pkg::oep_straps_t      straps,            // Straps.
	input wire logic                 powerDown          // Power-down.
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	////////////////////////////////////////////////////////////////
	chk_ref_float: assert property (!straps.valid |-> !referenceClockOe)
		else $error("ref driven before power-good");
	chk_ref_low: assert property (powerDown && straps.valid |-> referenceClockOe && !referenceClockOut)
		else $error("ref not low in power-down");
	chk_pair_low: assert property (!powerGoodPowerdownN [*3] |-> pairTrueOut == '0 && pairCompOut == '0)
		else $error("pair runs in power-down");
	chk_pair_comp: assert property ((pairTrueOut & pairCompOut) == '0)
		else $error("true and comp both high");
	chk_strap_hold: assert property (straps.valid |=> $stable(straps))
		else $error("straps changed");
	chk_strap_addr: assert property ($rose(straps.valid) |-> straps.slaveAddr == ($past(addressSelectStrapIn) ?
		oep_pkg::ADDR_STRAP_HIGH : oep_pkg::ADDR_STRAP_LOW))
		else $error("wrong slave address");
	chk_spread_map: assert property ($rose(straps.valid) |-> straps.spread == ($past(spreadSelectTri) ==
		oep_pkg::TRI_HIGH ? oep_pkg::SPREAD_HALF : $past(spreadSelectTri) == oep_pkg::TRI_MID ?
		oep_pkg::SPREAD_Q25 : oep_pkg::SPREAD_OFF))
		else $error("wrong spread");
	chk_pd_flag: assert property (!$past(reset) |-> powerDown == !$past(powerGoodPowerdownN))
		else $error("power-down flag wrong");
	chk_oe_stop: assert property ($rose(pairEnableN[0]) |-> ##[1:9] !(pairTrueOut[0] | pairCompOut[0]) [*3])
		else $error("pair 0 did not stop");
	chk_ref_oe_hold: assert property (straps.valid |=> referenceClockOe)
		else $error("shared pin released after start-up");
endmodule
bind oep_output_ctrl oep_output_ctrl_chk #(.NUM_PAIRS(NUM_PAIRS)) chk (.mclk(mclk), .reset(reset),
	.powerGoodPowerdownN(powerGoodPowerdownN), .pairEnableN(pairEnableN),
	.addressSelectStrapIn(addressSelectStrapIn), .spreadSelectTri(spreadSelectTri),
	.pairTrueOut(pairTrueOut), .pairCompOut(pairCompOut), .referenceClockOut(referenceClockOut),
	.referenceClockOe(referenceClockOe), .straps(straps), .powerDown(powerDown));

// ---- dv/test_output_enable_power_control.sv ----
`timescale 1ns/1ps
module test_output_enable_power_control;
	localparam int CC = 20;
	localparam int WC = 6;
	logic                 mclk = 1'h0, reset = 1'h1, pgDrv = 1'h0, pgOe = 1'h1, strapLvl = 1'h0;
	logic [3:0]           enDrv = 4'h0, enOe = 4'hF, mgmt = 4'h0;
	logic [1:0]           spd = 2'h0;
	logic                 pg, strapPin, refOut, refOe, pd;
	logic [3:0]           en, tOut, cOut;
	oep_pkg::oep_straps_t stp;
	oep_pkg::oep_straps_t qS[$];
	logic [3:0]           qR[$];
	logic [2:0]           qF[$];
	int                   bad_count = 0, tests_run = 0;
	event                 probe;
	initial forever #25 mclk = ~mclk;
	oep_pwr_model pm (.pgDrv(pgDrv), .pgOe(pgOe), .enDrv(enDrv), .enOe(enOe), .strapLvl(strapLvl),
		.refOut(refOut), .refOe(refOe), .pg(pg), .en(en), .strapPin(strapPin));
	oep_output_ctrl #(.COLD_CYC(CC), .WAKE_CYC(WC)) dut (.mclk(mclk), .reset(reset), .powerGoodPowerdownN(pg),
		.pairEnableN(en), .pairMgmtEnable(mgmt), .addressSelectStrapIn(strapPin), .spreadSelectTri(spd),
		.pairTrueOut(tOut), .pairCompOut(cOut), .referenceClockOut(refOut), .referenceClockOe(refOe),
		.straps(stp), .powerDown(pd));
	////////////////////////////////////////////////////////////////
	task automatic fail(input string s);
		bad_count++;
		$display("[FAIL] %0t %s", $time, s);
	endtask
	task automatic cmpStraps(input oep_pkg::oep_straps_t got, input oep_pkg::oep_straps_t exp);
		tests_run++;
		if (got !== exp) fail("straps");
	endtask
	task automatic cmpRun(input logic [3:0] got, input logic [3:0] exp);
		tests_run++;
		if (got !== exp) fail("pair activity");
	endtask
	task automatic cmpRef(input logic [2:0] got, input logic [2:0] exp);
		tests_run++;
		if (got !== exp) fail("reference pin");
	endtask
	task automatic checkRun(input logic [3:0] exp, input logic [2:0] rExp);
		qR.push_back(exp);
		qF.push_back(rExp);
		->probe;
		repeat (6) @(posedge mclk);
	endtask
	task automatic report_and_stop;
		// A result that never appeared leaves its note behind.
		if (qS.size() != 0 || qR.size() != 0 || qF.size() != 0) fail("results never seen");
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge stp.valid)
	begin
		#1;
		cmpStraps(stp, qS.pop_front());
	end
	// A pair counts as running only if it toggles and stays complementary; anything in between reads as unknown.
	initial forever
	begin
		logic [3:0] hi, lo, ok, cHi, run;
		logic       rHi, rLo;
		@(probe);
		{hi, lo, ok, cHi} = 16'h00F0;
		{rHi, rLo} = 2'h0;
		repeat (4)
		begin
			@(negedge mclk);
			hi |= tOut;
			lo |= ~tOut;
			ok &= tOut ^ cOut;
			cHi |= cOut;
			rHi |= refOut;
			rLo |= ~refOut;
		end
		run = hi & lo & ok;
		cmpRun(run | ((hi | cHi) & ~run & 4'hX), qR.pop_front());
		cmpRef({refOe, rHi, rLo}, qF.pop_front());
	end
	initial
	begin
		oep_pkg::oep_straps_t es;
		mgmt = 4'($urandom(32'hEB20));
		for (int i = 0; i < 4; i++)
		begin
			reset <= 1'h1;
			pgDrv <= 1'h0;
			pgOe <= 1'h1;
			strapLvl <= i[0];
			spd <= 2'(i);
			enOe <= (i == 1) ? 4'h0 : 4'hF;
			repeat (12) @(posedge mclk);
			reset <= 1'h0;
			repeat (3) @(posedge mclk);
			es = {1'h1, i[0] ? oep_pkg::ADDR_STRAP_HIGH : oep_pkg::ADDR_STRAP_LOW, i == 2 ? oep_pkg::SPREAD_HALF :
				i == 1 ? oep_pkg::SPREAD_Q25 : oep_pkg::SPREAD_OFF};
			qS.push_back(es);
			mgmt <= 4'($urandom);
			enDrv <= 4'($urandom);
			pgDrv <= 1'h1;
			@(posedge mclk);
			strapLvl <= ~strapLvl;
			spd <= 2'h2 - spd;
			repeat (CC + 12) @(posedge mclk);
			checkRun(~(enDrv & enOe) & mgmt, 3'h7);
			enDrv[0] <= ~enDrv[0];
			repeat (10) @(posedge mclk);
			checkRun(~(enDrv & enOe) & mgmt, 3'h7);
			pgDrv <= 1'h0;
			mgmt <= 4'($urandom);
			repeat (4) @(posedge mclk);
			checkRun(4'h0, 3'h5);
			if (i[0]) pgOe <= 1'h0;
			else pgDrv <= 1'h1;
			repeat (WC + 12) @(posedge mclk);
			checkRun(~(enDrv & enOe) & mgmt, 3'h7);
		end
		report_and_stop;
	end
	// Four rounds take about 416 cycles; the limit leaves ample slack.
	initial
	begin
		repeat (3000) @(posedge mclk);
		fail("timeout");
		report_and_stop;
	end
endmodule
